/* File: hdl/lcs_pkg.sv */
// Package: register map, field layout and reset values of the input select gate
package lcs_pkg;
    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [3:0] LCS_OFF_SEL   = 4'h0;
    localparam logic [3:0] LCS_OFF_GATE1 = 4'h4;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int LCS_CH3_LSB = 0;
    localparam int LCS_CH4_LSB = 4;
    localparam int LCS_SEL_W   = 3;
    localparam logic [7:0] LCS_SEL_MASK = 8'h77;

    // Gate-1 enable bit positions
    localparam int LCS_G1_CH4_TRUE = 7;
    localparam int LCS_G1_CH4_INV  = 6;
    localparam int LCS_G1_CH3_TRUE = 5;
    localparam int LCS_G1_CH3_INV  = 4;
    localparam int LCS_G1_CH2_TRUE = 3;
    localparam int LCS_G1_CH2_INV  = 2;
    localparam int LCS_G1_CH1_TRUE = 1;
    localparam int LCS_G1_CH1_INV  = 0;

    // ------------------------------------------------------------
    // Input base index per channel, values after power-on reset
    // ------------------------------------------------------------
    localparam logic [3:0] LCS_CH3_BASE = 4'h8;
    localparam logic [3:0] LCS_CH4_BASE = 4'hc;
    localparam logic [7:0] LCS_SEL_POR   = 8'h00;
    localparam logic [7:0] LCS_GATE1_POR = 8'h00;
endpackage

/* File: hdl/lcs_chan_if.sv */
// Interface: one data channel selector between the top and the mux
`timescale 1ns/1ps
`default_nettype none
interface lcs_chan_if;
    logic [2:0]  code;
    logic [15:0] inputs;
    logic        true_copy;
    logic        inv_copy;
    modport ctrl (output code, output inputs, input true_copy, input inv_copy);
    modport mux  (input code, input inputs, output true_copy, output inv_copy);
endinterface
`default_nettype wire

/* File: hdl/lcs_chan_sel.sv */
// Module: one data channel source mux with registered true and inverted copies
`timescale 1ns/1ps
`default_nettype none
module lcs_chan_sel
    import lcs_pkg::*;
#(
    parameter logic [3:0] BASE = 4'h8
) (
    input  wire logic  core_clk_i,
    lcs_chan_if.mux    ch
);
    logic [3:0] idx;

    // Input index is base plus code, wrapping past input 15
    assign idx = 4'(BASE + {1'b0, ch.code});

    // Registered copies of the selected input
    always_ff @(posedge core_clk_i) begin
        ch.true_copy <= ch.inputs[idx];
        ch.inv_copy  <= ~ch.inputs[idx];
    end
endmodule
`default_nettype wire

/* File: hdl/lcs_top.sv */
// Module: input select and gate-1 polarity enables of a logic cell, Avalon-MM slave
`timescale 1ns/1ps
`default_nettype none
module lcs_top
    import lcs_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        por_b_i,
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic [15:0] cell_in_i,
    input  wire logic        data_channel_1_i,
    input  wire logic        data_channel_2_i,
    output logic             data_channel_3_o,
    output logic             data_channel_4_o,
    output logic             chan3_inv_copy_o,
    output logic             chan4_inv_copy_o,
    output logic      [7:0]  gate_one_terms_o
);
    // ------------------------------------------------------------
    // Handshake states
    // ------------------------------------------------------------
    // Idle until a request, then one completing cycle
    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_DONE = 1'b1
    } lcs_bus_state_t;

    // ------------------------------------------------------------
    // Registers and internal nets
    // ------------------------------------------------------------
    lcs_bus_state_t bus_state_r;
    lcs_bus_state_t bus_state_nxt;
    logic [7:0]     data34_select_reg_r;
    logic [7:0]     gate1_polarity_enables_r;
    logic           access;
    logic           access_done;
    logic           lane0_en;
    logic           hit_sel;
    logic           hit_gate;
    logic           wr_sel;
    logic           wr_gate;
    logic           rd_load;
    logic [7:0]     rd_nxt;
    logic [2:0]     chan3_source_field;
    logic [2:0]     chan4_source_field;
    logic           chan3_true_copy;
    logic           chan4_true_copy;
    logic           chan3_inv_copy;
    logic           chan4_inv_copy;
    logic           g1_ch4_true_en;
    logic           g1_ch4_inv_en;
    logic           g1_ch3_true_en;
    logic           g1_ch3_inv_en;
    logic           g1_ch2_true_en;
    logic           g1_ch2_inv_en;
    logic           g1_ch1_true_en;
    logic           g1_ch1_inv_en;
    logic [7:0]     gate_one_terms_nxt;

    // Carriers between this module and the two source muxes
    lcs_chan_if ch3_if ();
    lcs_chan_if ch4_if ();

    // ------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------
    // Any request, read or write
    assign access = avs_read_i | avs_write_i;

    // Second cycle of a request completes it
    assign access_done       = access & (bus_state_r == BUS_DONE);
    assign avs_waitrequest_o = access & (bus_state_r == BUS_IDLE);

    // Next state: one wait cycle per access, back to back allowed
    always_comb begin
        bus_state_nxt = BUS_IDLE;
        case (bus_state_r)
            BUS_IDLE: begin
                if (access) begin
                    bus_state_nxt = BUS_DONE;
                end
            end
            BUS_DONE: begin
                bus_state_nxt = BUS_IDLE;
            end
            default: begin
                bus_state_nxt = BUS_IDLE;
            end
        endcase
    end

    // State register; cleared by the bus reset
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            bus_state_r <= BUS_IDLE;
        end else begin
            bus_state_r <= bus_state_nxt;
        end
    end

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // Only the low byte lane carries register data
    assign lane0_en = avs_byteenable_i[0];
    assign hit_sel  = (avs_address_i == LCS_OFF_SEL);
    assign hit_gate = (avs_address_i == LCS_OFF_GATE1);

    // Writes land at the completing edge, lane 0 required
    assign wr_sel  = avs_write_i & access_done & lane0_en & hit_sel;
    assign wr_gate = avs_write_i & access_done & lane0_en & hit_gate;

    // Read data fetched in the first cycle of a read
    assign rd_load = avs_read_i & (bus_state_r == BUS_IDLE);

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    // Select fields; only power-on clears, other resets keep value
    always_ff @(posedge core_clk_i) begin
        if (!por_b_i) begin
            data34_select_reg_r <= LCS_SEL_POR;
        end else if (wr_sel) begin
            data34_select_reg_r <= avs_writedata_i[7:0] & LCS_SEL_MASK;
        end
    end

    // Gate-1 enables; kept through the bus reset
    always_ff @(posedge core_clk_i) begin
        if (!por_b_i) begin
            gate1_polarity_enables_r <= LCS_GATE1_POR;
        end else if (wr_gate) begin
            gate1_polarity_enables_r <= avs_writedata_i[7:0];
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Read mux; unmapped addresses read zero
    always_comb begin
        rd_nxt = 8'h00;
        case (avs_address_i)
            LCS_OFF_SEL: begin
                rd_nxt = data34_select_reg_r & LCS_SEL_MASK;
            end
            LCS_OFF_GATE1: begin
                rd_nxt = gate1_polarity_enables_r;
            end
            default: begin
                rd_nxt = 8'h00;
            end
        endcase
    end

    // Read data stands at the edge where waitrequest is low
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (rd_load) begin
            avs_readdata_o <= {24'h00_0000, rd_nxt};
        end
    end

    // ------------------------------------------------------------
    // Gate-1 enable fields
    // ------------------------------------------------------------
    // One enable per channel copy, channel 4 true on top
    assign g1_ch4_true_en = gate1_polarity_enables_r[LCS_G1_CH4_TRUE];
    assign g1_ch4_inv_en  = gate1_polarity_enables_r[LCS_G1_CH4_INV];
    assign g1_ch3_true_en = gate1_polarity_enables_r[LCS_G1_CH3_TRUE];
    assign g1_ch3_inv_en  = gate1_polarity_enables_r[LCS_G1_CH3_INV];
    assign g1_ch2_true_en = gate1_polarity_enables_r[LCS_G1_CH2_TRUE];
    assign g1_ch2_inv_en  = gate1_polarity_enables_r[LCS_G1_CH2_INV];
    assign g1_ch1_true_en = gate1_polarity_enables_r[LCS_G1_CH1_TRUE];
    assign g1_ch1_inv_en  = gate1_polarity_enables_r[LCS_G1_CH1_INV];

    // ------------------------------------------------------------
    // Channel selection
    // ------------------------------------------------------------
    // Source fields of the select register
    assign chan3_source_field = data34_select_reg_r[LCS_CH3_LSB +: LCS_SEL_W];
    assign chan4_source_field = data34_select_reg_r[LCS_CH4_LSB +: LCS_SEL_W];

    // Both muxes see all sixteen shared inputs
    assign ch3_if.code   = chan3_source_field;
    assign ch3_if.inputs = cell_in_i;
    assign ch4_if.code   = chan4_source_field;
    assign ch4_if.inputs = cell_in_i;

    // Channel 3: inputs 8..15
    lcs_chan_sel #(.BASE(LCS_CH3_BASE)) u_ch3 (
        .core_clk_i (core_clk_i),
        .ch         (ch3_if.mux)
    );

    // Channel 4: inputs 12..15 then wraps to 0..3
    lcs_chan_sel #(.BASE(LCS_CH4_BASE)) u_ch4 (
        .core_clk_i (core_clk_i),
        .ch         (ch4_if.mux)
    );

    // Copies returned by the muxes, one cycle behind the inputs
    assign chan3_true_copy = ch3_if.true_copy;
    assign chan3_inv_copy  = ch3_if.inv_copy;
    assign chan4_true_copy = ch4_if.true_copy;
    assign chan4_inv_copy  = ch4_if.inv_copy;

    // Channel outputs for the rest of the cell
    assign data_channel_3_o = chan3_true_copy;
    assign data_channel_4_o = chan4_true_copy;
    assign chan3_inv_copy_o = chan3_inv_copy;
    assign chan4_inv_copy_o = chan4_inv_copy;

    // ------------------------------------------------------------
    // Gate-1 polarity gating
    // ------------------------------------------------------------
    // Each term is its copy when enabled, zero when not
    always_comb begin
        gate_one_terms_nxt = 8'h00;
        gate_one_terms_nxt[LCS_G1_CH4_TRUE] = g1_ch4_true_en & chan4_true_copy;
        gate_one_terms_nxt[LCS_G1_CH4_INV]  = g1_ch4_inv_en  & chan4_inv_copy;
        gate_one_terms_nxt[LCS_G1_CH3_TRUE] = g1_ch3_true_en & chan3_true_copy;
        gate_one_terms_nxt[LCS_G1_CH3_INV]  = g1_ch3_inv_en  & chan3_inv_copy;
        gate_one_terms_nxt[LCS_G1_CH2_TRUE] = g1_ch2_true_en & data_channel_2_i;
        gate_one_terms_nxt[LCS_G1_CH2_INV]  = g1_ch2_inv_en  & ~data_channel_2_i;
        gate_one_terms_nxt[LCS_G1_CH1_TRUE] = g1_ch1_true_en & data_channel_1_i;
        gate_one_terms_nxt[LCS_G1_CH1_INV]  = g1_ch1_inv_en  & ~data_channel_1_i;
    end

    // Terms registered for the cell's logic core
    always_ff @(posedge core_clk_i) begin
        gate_one_terms_o <= gate_one_terms_nxt;
    end
endmodule
`default_nettype wire

/* File: tb/lcs_properties.sv */
// Checker: bus handshake, readback and gate term properties
`timescale 1ns/1ps
`default_nettype none
module lcs_properties (
    input wire logic        core_clk_i,
    input wire logic        rst_b_i,
    input wire logic [3:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic        data_channel_1_i,
    input wire logic        data_channel_2_i,
    input wire logic        data_channel_3_o,
    input wire logic        data_channel_4_o,
    input wire logic        chan3_inv_copy_o,
    input wire logic        chan4_inv_copy_o,
    input wire logic [7:0]  gate_one_terms_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    // Read completing at this edge
    wire rd_done = avs_read_i && !avs_waitrequest_o;
    bus_wait_a: assert property ($rose(avs_read_i || avs_write_i) |->
        avs_waitrequest_o ##1 !avs_waitrequest_o) else $error("wait state wrong");
    ch3_invert_a: assert property (chan3_inv_copy_o == !data_channel_3_o)
        else $error("ch3 inverted copy wrong");
    ch4_invert_a: assert property (chan4_inv_copy_o == !data_channel_4_o)
        else $error("ch4 inverted copy wrong");
    g1_ch4_a: assert property (gate_one_terms_o[7] |-> $past(data_channel_4_o))
        else $error("ch4 true term wrong");
    g1_ch4n_a: assert property (gate_one_terms_o[6] |-> $past(chan4_inv_copy_o))
        else $error("ch4 inverted term wrong");
    g1_ch3_a: assert property ((gate_one_terms_o[5:4] &
        ~{$past(data_channel_3_o), $past(chan3_inv_copy_o)}) == 2'b00) else $error("ch3 term");
    g1_ch12_a: assert property ((gate_one_terms_o[3:0] & ~{$past(data_channel_2_i),
        !$past(data_channel_2_i), $past(data_channel_1_i), !$past(data_channel_1_i)}) == 4'h0)
        else $error("ch1 ch2 terms wrong");
    sel_rsvd_a: assert property (rd_done && avs_address_i == 4'h0 |->
        avs_readdata_o[7] == 1'b0 && avs_readdata_o[3] == 1'b0) else $error("reserved bit set");
    unmapped_a: assert property (rd_done && avs_address_i != 4'h0 && avs_address_i != 4'h4
        |-> avs_readdata_o == 32'h0) else $error("unmapped read not zero");
    cover property (rd_done);
    cover property (avs_write_i && !avs_waitrequest_o);
    cover property (gate_one_terms_o[7]);
endmodule
bind lcs_top lcs_properties u_chk (
    .core_clk_i        (core_clk_i),
    .rst_b_i           (rst_b_i),
    .avs_address_i     (avs_address_i),
    .avs_read_i        (avs_read_i),
    .avs_write_i       (avs_write_i),
    .avs_readdata_o    (avs_readdata_o),
    .avs_waitrequest_o (avs_waitrequest_o),
    .data_channel_1_i  (data_channel_1_i),
    .data_channel_2_i  (data_channel_2_i),
    .data_channel_3_o  (data_channel_3_o),
    .data_channel_4_o  (data_channel_4_o),
    .chan3_inv_copy_o  (chan3_inv_copy_o),
    .chan4_inv_copy_o  (chan4_inv_copy_o),
    .gate_one_terms_o  (gate_one_terms_o)
);
`default_nettype wire

/* File: tb/lcs_top_tb.sv */
// Testbench: register access, channel routing and gate-1 enables
`timescale 1ns/1ps
`default_nettype none
module lcs_top_tb;
    import lcs_pkg::*;
    logic        clk, rst_b, por_b, rd, wr, d1, d2, d3, d4, n3, n4, wt;
    logic [3:0]  adr, be;
    logic [15:0] cin;
    logic [31:0] wd, rdat, q;
    logic [7:0]  terms;
    int          n_errors = 0, num_checks = 0;
    lcs_top dut (.core_clk_i(clk), .rst_b_i(rst_b), .por_b_i(por_b), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wt), .cell_in_i(cin),
        .data_channel_1_i(d1), .data_channel_2_i(d2), .data_channel_3_o(d3),
        .data_channel_4_o(d4), .chan3_inv_copy_o(n3), .chan4_inv_copy_o(n4),
        .gate_one_terms_o(terms));
    // Clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One bus access, held until waitrequest is sampled low at a rising edge
    task automatic bus(logic w, logic [3:0] a, logic [7:0] d);
        @(posedge clk);
        adr <= a;
        wd <= {24'h000000, d};
        wr <= w;
        rd <= !w;
        do @(posedge clk); while (wt !== 1'b0);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic t_regs();
        bus(1'b1, LCS_OFF_SEL, 8'hff);
        bus(1'b0, LCS_OFF_SEL, 8'h00);
        chk("sel", 32'h77, q);
        be <= 4'he;
        bus(1'b1, LCS_OFF_SEL, 8'h00);
        be <= 4'hf;
        bus(1'b0, LCS_OFF_SEL, 8'h00);
        chk("sel_lane", 32'h77, q);
        bus(1'b1, LCS_OFF_GATE1, 8'ha5);
        @(posedge clk) rst_b <= 1'b0;
        @(posedge clk) rst_b <= 1'b1;
        bus(1'b0, LCS_OFF_GATE1, 8'h00);
        chk("gate1", 32'ha5, q);
        bus(1'b1, 4'h8, 8'hff);
        bus(1'b0, 4'h8, 8'h00);
        chk("unmapped", 32'h0, q);
    endtask
    // Every code on both channels, one-hot input
    task automatic t_route();
        for (int c = 0; c < 8; c++) begin
            bus(1'b1, LCS_OFF_SEL, {1'b0, c[2:0], 1'b0, c[2:0]});
            @(posedge clk) cin <= 16'h1 << ((12 + c) % 16);
            repeat (2) @(negedge clk);
            chk("ch4", 4'b1001, {d4, n4, d3, n3});
            @(posedge clk) cin <= 16'h1 << (8 + c);
            repeat (2) @(negedge clk);
            chk("ch3", 4'b0110, {d4, n4, d3, n3});
        end
    endtask
    // Enable patterns against two channel value sets
    task automatic t_gate();
        logic [7:0] en [5] = '{8'hff, 8'h0f, 8'hf0, 8'ha5, 8'h00};
        bus(1'b1, LCS_OFF_SEL, 8'h00);
        for (int v = 0; v < 2; v++) begin
            @(posedge clk);
            cin <= v ? 16'h1000 : 16'h0100;
            d1 <= !v;
            d2 <= v[0];
            foreach (en[i]) begin
                bus(1'b1, LCS_OFF_GATE1, en[i]);
                repeat (2) @(negedge clk);
                chk("terms", en[i] & (v ? 8'h99 : 8'h66), terms);
            end
        end
    endtask
    task automatic end_of_test();
        if (n_errors == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        {rd, wr, adr, wd, cin, d1, d2} = '0;
        be = 4'hf;
        rst_b = 1'b0;
        por_b = 1'b0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        por_b <= 1'b1;
        t_regs();
        t_route();
        t_gate();
        end_of_test();
    end
    // Watchdog
    initial begin
        #100000;
        n_errors++;
        end_of_test();
    end
endmodule
`default_nettype wire
